/* File: hdl/latc_core.sv */
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
//
// Contract
// - masked bits never block a word match
// - each module samples four channels normally
// - accept slow time-base sample clock
// - two selectable fast internal sample clocks
// - half_channel_fine_sampling mode uses two channels, steering
// - sampling is asynchronous to probed data
// - armed mode: recognizer enabled after slow trigger
// - arming delay at most ten slow periods
// - center position keeps acquiring half record
// - external clock on rising or falling edge
// - expanders share master sample clock, combining
// - 2048-sample memory, identical repeated cycles
module latc_core import latc_pkg::*; #(
   parameter int NMOD = 2,
   parameter int DEPTH = MEM_DEPTH
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // probes and clocks
   input wire logic [NMOD*CH_PER_MOD-1:0] probe_data,
   input wire logic ext_clk,
   input wire logic tb_clk,
   input wire logic slow_card_enables_fast,
   // to expanders and system
   output logic samp_strobe,
   output logic trig_out,
   output logic acq_busy
);

   localparam int W = NMOD * CH_PER_MOD;
   localparam int AW = $clog2(DEPTH);
   localparam int F5 = FAST5_CYC;
   localparam int F3 = FAST3_CYC;
   localparam int HRC = HIRES_CYC;
   localparam int ARMC = ARM_MAX_CYC;
   localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);

   latc_cfg_t cfg_r;
   latc_state_t st_r;
   logic [W-1:0] tword_r, tmask_r;
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_addr_r, taddr_r, ridx_r;
   logic [AW:0] post_cnt_r;
   logic [7:0] div_r;
   logic ext_q_r, tb_q_r;
   logic [W-1:0] word_r;
   logic [NMOD*HR_CH-1:0] steer_r;
   logic samp_v_r, hr_phase_r, armed_r, start_r, seen_trig_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r, trig_r, acq_busy_r;
   logic [NMOD-1:0] mod_match;
   logic all_match, recog_en, raw_samp, int_tick;
   logic [7:0] div_max;
   logic [31:0] rd_mux;
   logic rd_ok;
   logic wr_go;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign trig_out = trig_r;
   assign samp_strobe = samp_v_r;
   assign acq_busy = acq_busy_r;
   assign wr_go = psel && penable && pready_r && pwrite;

   // apb register access
   always_comb begin
      rd_ok = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         OFF_CTRL: rd_mux = 32'(cfg_r) << CTL_CSEL;
         OFF_TWORD: rd_mux = 32'(tword_r);
         OFF_TMASK: rd_mux = 32'(tmask_r);
         OFF_STAT: rd_mux = {24'h00_0000, 1'b0, armed_r, seen_trig_r, 5'(st_r)};
         OFF_TADDR: rd_mux = 32'(taddr_r);
         OFF_RIDX: rd_mux = 32'(ridx_r);
         OFF_RDATA: rd_mux = 32'(mem[ridx_r]);
         default: rd_ok = 1'b0;
      endcase
   end

   // zero wait state: answer sits ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= psel && !penable;
         pslverr_r <= psel && !penable && !rd_ok;
         prdata_r <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= '{center: 1'b0, arm_mode: 1'b0, hires: 1'b0, ext_fall: 1'b0, csel: CS_INT5};
         tword_r <= W'(RST_TWORD);
         tmask_r <= W'(RST_TMASK);
         ridx_r <= '0;
         start_r <= 1'b0;
      end else begin
         start_r <= 1'b0;
         if (wr_go && !pslverr_r) begin
            case (paddr)
               OFF_CTRL: begin
                  cfg_r <= latc_cfg_t'(pwdata[CTL_CENTER:CTL_CSEL]);
                  start_r <= pwdata[CTL_START];
               end
               OFF_TWORD: tword_r <= pwdata[W-1:0];
               OFF_TMASK: tmask_r <= pwdata[W-1:0];
               OFF_RIDX: ridx_r <= pwdata[AW-1:0];
               default: ;
            endcase
         end
      end
   end

   // sample clock selection
   // every internal rate is folded onto pclk; below one pclk period
   // the divider saturates at one sample per cycle
   always_comb begin
      case (cfg_r.csel)
         CS_INT3: div_max = 8'(F3 - 1);
         default: div_max = 8'(F5 - 1);
      endcase
      if (cfg_r.hires) begin
         div_max = 8'(HRC - 1);
      end
   end

   assign int_tick = div_r == 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 8'h00;
      end else begin
         div_r <= int_tick ? div_max : div_r - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_q_r <= 1'b0;
         tb_q_r <= 1'b0;
      end else begin
         ext_q_r <= ext_clk;
         tb_q_r <= tb_clk;
      end
   end

   always_comb begin
      case (cfg_r.csel)
         CS_TBASE: raw_samp = tb_clk && !tb_q_r;
         CS_EXT: raw_samp = cfg_r.ext_fall ? (!ext_clk && ext_q_r)
                                           : (ext_clk && !ext_q_r);
         default: raw_samp = int_tick;
      endcase
   end

   // capture and steering, per module
   // probe data is free-running; a sample lands wherever the strobe falls,
   // so an edge can move by one sample either way
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hr_phase_r <= 1'b0;
         samp_v_r <= 1'b0;
      end else begin
         if (raw_samp && cfg_r.hires) begin
            hr_phase_r <= !hr_phase_r;
         end else if (!cfg_r.hires) begin
            hr_phase_r <= 1'b0;
         end
         samp_v_r <= raw_samp && (!cfg_r.hires || hr_phase_r);
      end
   end

   genvar g;
   generate
      for (g = 0; g < NMOD; g++) begin : g_mod
         localparam int B = g * CH_PER_MOD;
         localparam int S = g * HR_CH;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               steer_r[S +: HR_CH] <= '0;
               word_r[B +: CH_PER_MOD] <= '0;
            end else if (raw_samp) begin
               if (!cfg_r.hires) begin
                  word_r[B +: CH_PER_MOD] <= probe_data[B +: CH_PER_MOD];
               end else if (!hr_phase_r) begin
                  steer_r[S +: HR_CH] <= probe_data[B +: HR_CH];
               end else begin
                  word_r[B +: CH_PER_MOD] <= {probe_data[B +: HR_CH], steer_r[S +: HR_CH]};
               end
            end
         end
         // per module masked compare; combined below across modules
         assign mod_match[g] = ((word_r[B +: CH_PER_MOD] ^ tword_r[B +: CH_PER_MOD])
                               & ~tmask_r[B +: CH_PER_MOD]) == '0;
      end
   endgenerate

   assign all_match = &mod_match;

   // arming by the slow card; its trigger beats a clear in the same cycle
   assign recog_en = !cfg_r.arm_mode || armed_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_r <= 1'b0;
      end else if (st_r == ST_ARM && slow_card_enables_fast) begin
         armed_r <= 1'b1;
      end else if (start_r) begin
         armed_r <= 1'b0;
      end
   end

   // acquisition sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_IDLE;
         acq_busy_r <= 1'b0;
         post_cnt_r <= '0;
         taddr_r <= '0;
         seen_trig_r <= 1'b0;
         trig_r <= 1'b0;
      end else begin
         trig_r <= 1'b0;
         case (st_r)
            ST_IDLE, ST_DONE: begin
               if (start_r) begin
                  st_r <= cfg_r.arm_mode ? ST_ARM : ST_HUNT;
                  acq_busy_r <= 1'b1;
                  seen_trig_r <= 1'b0;
               end
            end
            ST_ARM: begin
               if (armed_r) begin
                  st_r <= ST_HUNT;
               end
            end
            ST_HUNT: begin
               if (samp_v_r && recog_en && all_match) begin
                  st_r <= ST_POST;
                  post_cnt_r <= '0;
                  taddr_r <= wr_addr_r;
                  seen_trig_r <= 1'b1;
                  trig_r <= 1'b1;
               end
            end
            ST_POST: begin
               if (!cfg_r.center) begin
                  st_r <= ST_DONE;
                  acq_busy_r <= 1'b0;
               end else if (samp_v_r) begin
                  post_cnt_r <= post_cnt_r + (AW+1)'(1);
                  if (post_cnt_r == HALF - (AW+1)'(1)) begin
                     st_r <= ST_DONE;
                     acq_busy_r <= 1'b0;
                  end
               end
            end
            default: begin
               st_r <= ST_IDLE;
               acq_busy_r <= 1'b0;
            end
         endcase
      end
   end

   // write pointer restarts at zero each run so every cycle repeats exactly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_addr_r <= '0;
      end else if (start_r) begin
         wr_addr_r <= '0;
      end else if (samp_v_r && (st_r == ST_HUNT || st_r == ST_ARM || st_r == ST_POST)) begin
         wr_addr_r <= (wr_addr_r == AW'(DEPTH - 1)) ? '0 : wr_addr_r + AW'(1);
      end
   end

   // storage carries no reset; contents are only meaningful after a run
   always_ff @(posedge pclk) begin
      if (samp_v_r && (st_r == ST_HUNT || st_r == ST_ARM || st_r == ST_POST)) begin
         mem[wr_addr_r] <= word_r;
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_masked_match: assert property (
      st_r == ST_HUNT && samp_v_r && recog_en
      && (((word_r ^ tword_r) & ~tmask_r) == '0) |=> st_r == ST_POST && trig_r)
      else $error("masked match did not trigger");
   chk_all_modules: assert property (
      st_r == ST_HUNT ##1 st_r == ST_POST |-> $past(all_match) && $past(samp_v_r))
      else $error("trigger without full match");
   chk_tbase_strobe: assert property (
      cfg_r.csel == CS_TBASE && !cfg_r.hires && tb_clk && !tb_q_r |=> samp_v_r)
      else $error("time-base edge not sampled");
   chk_fast_rate: assert property (
      cfg_r.csel == CS_INT5 && !cfg_r.hires && $stable(cfg_r) |-> ##[0:F5] samp_v_r)
      else $error("fast internal clock stalled");
   chk_hires_pair: assert property (
      cfg_r.hires && $past(cfg_r.hires) && samp_v_r |-> $past(hr_phase_r) && !hr_phase_r)
      else $error("half_channel_fine_sampling word without steering pair");
   chk_arm_gate: assert property (
      cfg_r.arm_mode && !armed_r && st_r != ST_POST |=> st_r != ST_POST)
      else $error("fast trigger before arming");
   chk_arm_delay: assert property (
      st_r == ST_ARM && slow_card_enables_fast |-> ##[1:ARMC] st_r == ST_HUNT)
      else $error("arming too slow");
   chk_ext_edge: assert property (
      cfg_r.csel == CS_EXT && !cfg_r.hires && cfg_r.ext_fall && !ext_clk && ext_q_r
      |=> samp_v_r && word_r == $past(probe_data))
      else $error("falling external edge missed");
   chk_wrap: assert property (
      st_r == ST_HUNT && samp_v_r && wr_addr_r == AW'(DEPTH - 1) && !start_r
      |=> wr_addr_r == '0)
      else $error("write pointer did not wrap");

endmodule // latc_core

/* File: hdl/latc_pkg.sv */
package latc_pkg;

   // channel layout
   localparam int CH_PER_MOD = 4;
   localparam int HR_CH = 2;
   localparam int MEM_DEPTH = 2048;

   // apb byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TWORD = 8'h04;
   localparam logic [7:0] OFF_TMASK = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_TADDR = 8'h10;
   localparam logic [7:0] OFF_RIDX = 8'h14;
   localparam logic [7:0] OFF_RDATA = 8'h18;

   // control field positions
   localparam int CTL_START = 0;
   localparam int CTL_CSEL = 1;
   localparam int CTL_EXTFALL = 3;
   localparam int CTL_HIRES = 4;
   localparam int CTL_ARM = 5;
   localparam int CTL_CENTER = 6;
   localparam logic [31:0] RST_TWORD = 32'h0000_0000;
   localparam logic [31:0] RST_TMASK = 32'h0000_0000;

   // timing, in picoseconds
   localparam int CLK_PERIOD_PS = 40000;
   localparam int FAST5_PS = 5000;
   localparam int FAST3_PS = 3000;
   localparam int HIRES_PS = 1500;
   localparam int TBASE_PS = 50000;
   localparam int ARM_SLOW_PERIODS = 10;

   function automatic int cyc_up(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      if (c < 1) begin
         c = 1;
      end
      return c;
   endfunction

   localparam int FAST5_CYC = cyc_up(FAST5_PS);
   localparam int FAST3_CYC = cyc_up(FAST3_PS);
   localparam int HIRES_CYC = cyc_up(HIRES_PS);
   localparam int TBASE_CYC = cyc_up(TBASE_PS);
   localparam int ARM_MAX_CYC = ARM_SLOW_PERIODS * TBASE_CYC;

   typedef enum logic [1:0] {
      CS_INT5 = 2'h0,
      CS_INT3 = 2'h1,
      CS_TBASE = 2'h2,
      CS_EXT = 2'h3
   } latc_csel_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ARM = 5'h02,
      ST_HUNT = 5'h04,
      ST_POST = 5'h08,
      ST_DONE = 5'h10
   } latc_state_t;

   typedef struct packed {
      logic center;
      logic arm_mode;
      logic hires;
      logic ext_fall;
      latc_csel_t csel;
   } latc_cfg_t;

endpackage

/* File: dv/latc_probe_model.sv */
`timescale 1ns/1ps
module latc_probe_model import latc_pkg::*; #(
   parameter int NMOD = 2
) (
   // clock
   input wire logic pclk,
   // bench control
   input wire logic arm_go,
   // probed target and slow card
   output logic [NMOD*CH_PER_MOD-1:0] probe_data,
   output logic ext_clk,
   output logic tb_clk,
   output logic slow_card_enables_fast
);
   // target runs free, never reset by the analyzer, so starts land at any phase
   logic [7:0] cnt_r = 8'h00;
   logic [2:0] idx_r = 3'h0;
   logic arm_r = 1'b0;
   logic [3:0] pat;
   // each word is held 16 cycles so every selectable clock sees it
   always_ff @(posedge pclk) begin
      cnt_r <= cnt_r + 8'h01;
      if (cnt_r[3:0] == 4'hF) begin
         idx_r <= (idx_r == 3'h5) ? 3'h0 : idx_r + 3'h1;
      end
   end
   always_ff @(posedge pclk) begin
      arm_r <= arm_go;
   end
   always_comb begin
      case (idx_r)
         3'h0: pat = 4'h0;
         3'h1: pat = 4'h1;
         3'h2: pat = 4'h2;
         3'h3: pat = 4'h4;
         3'h4: pat = 4'h8;
         default: pat = 4'hF;
      endcase
   end
   assign probe_data = {NMOD{pat}};
   assign ext_clk = cnt_r[2];
   assign tb_clk = (int'(cnt_r) % (2 * TBASE_CYC)) >= TBASE_CYC;
   assign slow_card_enables_fast = arm_r;
endmodule // latc_probe_model

/* File: dv/latc_core_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module latc_core_tb import latc_pkg::*;;
   localparam int NM = 2;
   localparam int DEP = 16;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic arm_go = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, samp_strobe, trig_out, acq_busy, ext_clk, tb_clk, slow_en, er;
   logic [NM*CH_PER_MOD-1:0] probe_data;
   int failures = 0, checks = 0;
   always #20 pclk = ~pclk;
   latc_core #(.NMOD(NM), .DEPTH(DEP)) latc_core_inst (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .probe_data(probe_data),
      .ext_clk(ext_clk), .tb_clk(tb_clk), .slow_card_enables_fast(slow_en),
      .samp_strobe(samp_strobe), .trig_out(trig_out), .acq_busy(acq_busy));
   latc_probe_model #(.NMOD(NM)) latc_probe_model_inst (.pclk(pclk), .arm_go(arm_go),
      .probe_data(probe_data), .ext_clk(ext_clk), .tb_clk(tb_clk),
      .slow_card_enables_fast(slow_en));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      `CHK("apb ready", 1'b1, pready)
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic run(input latc_cfg_t c, input logic [7:0] w, input logic [7:0] m,
      input logic exp);
      int n, s;
      logic [31:0] ta;
      apb(1'b1, OFF_TWORD, {24'h0, w});
      apb(1'b1, OFF_TMASK, {24'h0, m});
      apb(1'b1, OFF_CTRL, {25'h0, c, 1'b0});
      apb(1'b0, OFF_CTRL, 32'h0);
      `CHK("ctrl", {25'h0, c, 1'b0}, rd)
      apb(1'b1, OFF_CTRL, {25'h0, c, 1'b1});
      n = 0;
      if (c.arm_mode) begin
         // matching words pass by here, so any trigger is premature
         repeat (150) begin
            @(posedge pclk);
            if (trig_out === 1'b1) n++;
         end
         `CHK("early trig", 0, n)
         arm_go <= 1'b1;
         @(posedge pclk);
         arm_go <= 1'b0;
         n = 0;
      end
      while (trig_out !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      `CHK("trig", exp, trig_out)
      if (c.arm_mode) `CHK("arm delay", 1'b1, n <= ARM_MAX_CYC + 100)
      if (!exp) return;
      s = 0;
      n = 0;
      while (acq_busy === 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
         if (samp_strobe === 1'b1) s++;
      end
      if (c.center) `CHK("post count", DEP / 2, s)
      `CHK("done", 1'b0, acq_busy)
      apb(1'b0, OFF_TADDR, 32'h0);
      ta = rd;
      apb(1'b1, OFF_RIDX, ta);
      apb(1'b0, OFF_RDATA, 32'h0);
      `CHK("stored word", w & ~m, rd[7:0] & ~m)
   endtask
   task automatic t_clocks;
      logic [7:0] w [5] = '{8'h11, 8'h22, 8'h44, 8'h88, 8'hFF};
      for (int i = 0; i < 5; i++) begin
         run('{1'b0, 1'b0, 1'b0, i == 4, latc_csel_t'(i > 3 ? 3 : i)}, w[i], 8'h00, 1'b1);
      end
   endtask
   task automatic t_mask;
      logic [3:0] b;
      for (int i = 0; i < 4; i++) begin
         b = 4'h1 << i;
         run('{1'b0, 1'b0, 1'b0, 1'b0, CS_INT5}, {2{b}}, ~{2{b}}, 1'b1);
      end
   endtask
   task automatic t_hires;
      run('{1'b0, 1'b0, 1'b1, 1'b0, CS_INT5}, 8'h55, 8'h00, 1'b1);
   endtask
   task automatic t_arm;
      run('{1'b1, 1'b1, 1'b0, 1'b0, CS_INT3}, 8'h11, 8'h00, 1'b1);
   endtask
   task automatic t_nomatch;
      // modules never show 1 and 2 together, so only a partial match exists
      run('{1'b0, 1'b0, 1'b0, 1'b0, CS_INT5}, 8'h12, 8'h00, 1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK("busy in reset", 1'b0, acq_busy)
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, OFF_TWORD, 32'h0);
      `CHK("tword reset", RST_TWORD, rd)
      apb(1'b0, OFF_TMASK, 32'h0);
      `CHK("tmask reset", RST_TMASK, rd)
      apb(1'b0, 8'h1C, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
   endtask
   task automatic results;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #800000;
      failures++;
      results;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_clocks;
      t_mask;
      t_hires;
      t_arm;
      t_nomatch;
      results;
   end
endmodule // latc_core_tb
